/* File: src/dpbr_pkg.sv */
// shared types, sizes and lane-steering helpers of the dual-port block ram
// assumes a single clock domain; both ports are driven by fabric logic
package dpbr_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int ADDR_W = 14; // widest port address (1-bit mode)
    localparam int ROW_AW = 9; // physical row index width
    localparam int DEPTH = 512; // physical rows
    localparam int DATA_W = 32; // data bits per row
    localparam int PAR_W = 4; // parity bits per row
    localparam int ROW_W = 36; // full row width
    localparam int LANE_W = 5; // widest lane select (1-bit mode)
    localparam logic [5:0] PAR_MODE_BASE = 6'h03; // first parity mode code
    localparam logic [31:0] RESET_DATA = 32'h0; // output value after reset
    localparam logic [3:0] RESET_PAR = 4'h0; // output parity after reset

    // ------------------------------------------------------------
    // modes
    // ------------------------------------------------------------
    // code equals log2 of the data lane width
    typedef enum logic [2:0] {
        DPBR_W1 = 3'h0,
        DPBR_W2 = 3'h1,
        DPBR_W4 = 3'h2,
        DPBR_W9 = 3'h3,
        DPBR_W18 = 3'h4,
        DPBR_W36 = 3'h5
    } dpbr_width_t;

    // what the output shows during a write
    typedef enum logic {
        DPBR_WRITE_THROUGH = 1'h0,
        DPBR_READ_BEFORE = 1'h1
    } dpbr_wmode_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic en; // port enable
        logic we; // write strobe
        dpbr_wmode_t wr_mode; // output choice on write
        dpbr_width_t width; // aspect ratio
        logic [ADDR_W-1:0] addr; // location
        logic [DATA_W-1:0] input_word; // data in
        logic [PAR_W-1:0] input_parity; // parity in
    } dpbr_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] output_word; // data out
        logic [PAR_W-1:0] output_parity; // parity out
    } dpbr_resp_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // data lane width in bits
    function automatic logic [5:0] dbits(dpbr_width_t w);
        dbits = 6'(6'h1 << w);
    endfunction

    // parity lane width in bits (zero without parity)
    function automatic logic [5:0] pbits(dpbr_width_t w);
        pbits = (6'(w) >= PAR_MODE_BASE) ? 6'(6'h1 << (6'(w) - PAR_MODE_BASE))
                                         : 6'h0;
    endfunction

    // number of address bits that pick the lane inside a row
    function automatic logic [2:0] lane_bits(dpbr_width_t w);
        lane_bits = 3'(3'h5 - 3'(w));
    endfunction

    function automatic logic [DATA_W-1:0] dmask(dpbr_width_t w);
        dmask = 32'((33'h1 << dbits(w)) - 33'h1);
    endfunction

    function automatic logic [PAR_W-1:0] pmask(dpbr_width_t w);
        pmask = 4'((5'h1 << pbits(w)) - 5'h1);
    endfunction

    function automatic logic [5:0] dshift(dpbr_width_t w,
                                          logic [LANE_W-1:0] lane);
        dshift = 6'(6'(lane) << w);
    endfunction

    function automatic logic [5:0] pshift(dpbr_width_t w,
                                          logic [LANE_W-1:0] lane);
        pshift = (6'(w) >= PAR_MODE_BASE)
               ? 6'(6'(lane) << (6'(w) - PAR_MODE_BASE)) : 6'h0;
    endfunction

    // pick one location's word out of a physical row
    function automatic dpbr_resp_t extract(logic [ROW_W-1:0] row,
                                           dpbr_width_t w,
                                           logic [LANE_W-1:0] lane);
        dpbr_resp_t r;
        r.output_word = (row[DATA_W-1:0] >> dshift(w, lane)) & dmask(w);
        r.output_parity = (row[ROW_W-1:DATA_W] >> pshift(w, lane)) & pmask(w);
        extract = r;
    endfunction

endpackage

/* File: src/dpbr_lane.sv */
// address and lane steering of one ram port
// assumes the request comes from logic on the same clock
`timescale 1ns/1ps

module dpbr_lane
(
    input wire dpbr_pkg::dpbr_req_t req_i,
    output logic [dpbr_pkg::ROW_AW-1:0] row_o,
    output logic [dpbr_pkg::LANE_W-1:0] lane_o,
    output logic [dpbr_pkg::ROW_W-1:0] mask_o,
    output logic [dpbr_pkg::ROW_W-1:0] word_o
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // high address bits pick the row, upper unused ones are dropped
    wire [dpbr_pkg::ADDR_W-1:0] row_full;
    // low address bits pick the lane
    wire [dpbr_pkg::ADDR_W-1:0] lane_full;
    wire [5:0] ds;
    wire [5:0] ps;

    assign row_full = req_i.addr >> dpbr_pkg::lane_bits(req_i.width);
    assign lane_full = req_i.addr
        & 14'((15'h1 << dpbr_pkg::lane_bits(req_i.width)) - 15'h1);
    assign row_o = row_full[dpbr_pkg::ROW_AW-1:0];
    assign lane_o = lane_full[dpbr_pkg::LANE_W-1:0];
    assign ds = dpbr_pkg::dshift(req_i.width, lane_o);
    assign ps = dpbr_pkg::pshift(req_i.width, lane_o);

    // ------------------------------------------------------------
    // write steering
    // ------------------------------------------------------------
    // bits of the row that this location owns
    assign mask_o = {dpbr_pkg::pmask(req_i.width) << ps,
                     dpbr_pkg::dmask(req_i.width) << ds};
    // incoming word placed on its lane
    assign word_o = {(req_i.input_parity & dpbr_pkg::pmask(req_i.width)) << ps,
                     (req_i.input_word & dpbr_pkg::dmask(req_i.width)) << ds};

endmodule

/* File: src/dpbr_top.sv */
// dual-port block ram, 512 rows of 32 data and 4 parity bits
// assumes both ports are driven by fabric logic on mclk_i
`timescale 1ns/1ps

module dpbr_top
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire dpbr_pkg::dpbr_req_t port_a_i,
    input wire dpbr_pkg::dpbr_req_t port_b_i,
    output dpbr_pkg::dpbr_resp_t resp_a_o,
    output dpbr_pkg::dpbr_resp_t resp_b_o
);

    // ------------------------------------------------------------
    // storage and steering
    // ------------------------------------------------------------
    // the array itself, not reset
    logic [dpbr_pkg::ROW_W-1:0] mem [dpbr_pkg::DEPTH];
    logic [dpbr_pkg::ROW_AW-1:0] row_a;
    logic [dpbr_pkg::ROW_AW-1:0] row_b;
    logic [dpbr_pkg::LANE_W-1:0] lane_a;
    logic [dpbr_pkg::LANE_W-1:0] lane_b;
    logic [dpbr_pkg::ROW_W-1:0] mask_a;
    logic [dpbr_pkg::ROW_W-1:0] mask_b;
    logic [dpbr_pkg::ROW_W-1:0] word_a;
    logic [dpbr_pkg::ROW_W-1:0] word_b;
    // output registers
    dpbr_pkg::dpbr_resp_t out_a_q;
    dpbr_pkg::dpbr_resp_t out_a_d;
    dpbr_pkg::dpbr_resp_t out_b_q;
    dpbr_pkg::dpbr_resp_t out_b_d;

    // per-port row and lane decode
    dpbr_lane u_lane_a
    (
        .req_i(port_a_i),
        .row_o(row_a),
        .lane_o(lane_a),
        .mask_o(mask_a),
        .word_o(word_a)
    );

    dpbr_lane u_lane_b
    (
        .req_i(port_b_i),
        .row_o(row_b),
        .lane_o(lane_b),
        .mask_o(mask_b),
        .word_o(word_b)
    );

    // ------------------------------------------------------------
    // write path
    // ------------------------------------------------------------
    wire wr_a;
    wire wr_b;
    wire same_row;
    wire [dpbr_pkg::ROW_W-1:0] old_a;
    wire [dpbr_pkg::ROW_W-1:0] old_b;
    wire [dpbr_pkg::ROW_W-1:0] new_a;
    wire [dpbr_pkg::ROW_W-1:0] new_b;
    wire [dpbr_pkg::ROW_W-1:0] base_b;

    // a write needs both strobe and enable
    assign wr_a = port_a_i.en & port_a_i.we;
    assign wr_b = port_b_i.en & port_b_i.we;
    assign same_row = wr_a & wr_b & (row_a == row_b);
    assign old_a = mem[row_a];
    assign old_b = mem[row_b];
    // merge each incoming word into its row, other lanes untouched
    assign new_a = (old_a & ~mask_a) | (word_a & mask_a);
    // port b merges over port a's result when both hit one row
    assign base_b = same_row ? new_a : old_b;
    assign new_b = (base_b & ~mask_b) | (word_b & mask_b);

    // both ports write on the same edge; on a shared row b lands last
    always_ff @(posedge mclk_i)
    begin
        if (wr_a)
        begin
            mem[row_a] <= new_a;
        end
        if (wr_b)
        begin
            mem[row_b] <= new_b;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // next output value of one port
    function automatic dpbr_pkg::dpbr_resp_t next_out(
        dpbr_pkg::dpbr_req_t req,
        logic [dpbr_pkg::ROW_W-1:0] old_row,
        logic [dpbr_pkg::ROW_W-1:0] new_row,
        logic [dpbr_pkg::LANE_W-1:0] lane,
        dpbr_pkg::dpbr_resp_t held);
        dpbr_pkg::dpbr_resp_t r;
        r = held;
        if (req.en && !req.we)
        begin
            // plain read of the addressed location
            r = dpbr_pkg::extract(old_row, req.width, lane);
        end
        else if (req.en && req.wr_mode == dpbr_pkg::DPBR_WRITE_THROUGH)
        begin
            // the word being written
            r = dpbr_pkg::extract(new_row, req.width, lane);
        end
        else if (req.en)
        begin
            // the word being replaced
            r = dpbr_pkg::extract(old_row, req.width, lane);
        end
        next_out = r;
    endfunction

    assign out_a_d = next_out(port_a_i, old_a, new_a, lane_a, out_a_q);
    assign out_b_d = next_out(port_b_i, old_b, new_b, lane_b, out_b_q);

    // output registers, cleared by reset
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            out_a_q <= {dpbr_pkg::RESET_DATA, dpbr_pkg::RESET_PAR};
            out_b_q <= {dpbr_pkg::RESET_DATA, dpbr_pkg::RESET_PAR};
        end
        else
        begin
            out_a_q <= out_a_d;
            out_b_q <= out_b_d;
        end
    end

    assign resp_a_o = out_a_q;
    assign resp_b_o = out_b_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // disabled port a holds its output
    a_hold_port_a: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        !port_a_i.en |=> $stable(resp_a_o))
        else $error("port a output moved while disabled");

    // port b untouched by port a traffic when disabled
    a_hold_port_b: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        !port_b_i.en && port_a_i.en |=> $stable(resp_b_o))
        else $error("port b output moved by port a");

    // 1-bit port uses address bits 13..5 as row
    a_row_wide_addr: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        port_a_i.width == dpbr_pkg::DPBR_W1
        |-> row_a == port_a_i.addr[13:5] && lane_a == port_a_i.addr[4:0])
        else $error("1-bit row decode wrong");

    // 36-bit port uses address bits 8..0 as row
    a_row_par_addr: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        port_b_i.width == dpbr_pkg::DPBR_W36
        |-> row_b == port_b_i.addr[8:0] && mask_b == {36{1'b1}})
        else $error("36-bit row decode wrong");

    // a lone write of port a lands in its row
    a_write_lands: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        wr_a && !(wr_b && row_a == row_b)
        |=> (mem[$past(row_a)] & $past(mask_a))
            == ($past(word_a) & $past(mask_a)))
        else $error("port a write not stored");

    // port b lands last on a shared row, so its write always shows
    a_write_lands_b: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        wr_b
        |=> (mem[$past(row_b)] & $past(mask_b))
            == ($past(word_b) & $past(mask_b)))
        else $error("port b write not stored");

    // read returns the stored word a cycle later
    a_read_data: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        port_a_i.en && !port_a_i.we && !wr_b
        ##1 !port_a_i.en && !wr_b
        |=> resp_a_o == dpbr_pkg::extract(mem[$past(row_a, 2)],
                                          $past(port_a_i.width, 2),
                                          $past(lane_a, 2)))
        else $error("read data differs from memory");

    // write-through shows the masked input word
    a_write_thru: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        wr_a && port_a_i.wr_mode == dpbr_pkg::DPBR_WRITE_THROUGH
        |=> resp_a_o.output_word
            == ($past(port_a_i.input_word)
                & dpbr_pkg::dmask($past(port_a_i.width))))
        else $error("write-through output wrong");

    // write-through on port b shows its own masked input word
    a_thru_port_b: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        wr_b && port_b_i.wr_mode == dpbr_pkg::DPBR_WRITE_THROUGH
        |=> resp_b_o.output_word
            == ($past(port_b_i.input_word)
                & dpbr_pkg::dmask($past(port_b_i.width))))
        else $error("port b write-through output wrong");

    // read-before-write shows the replaced word
    a_read_before: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        wr_b && port_b_i.wr_mode == dpbr_pkg::DPBR_READ_BEFORE
        |=> resp_b_o == dpbr_pkg::extract($past(old_b),
                                          $past(port_b_i.width),
                                          $past(lane_b)))
        else $error("read-before-write output wrong");

endmodule

/* File: testbench/dpbr_fabric.sv */
// partner model: fabric logic issuing requests on one ram port
// assumes the bench calls its tasks just after a falling clock edge
`timescale 1ns/1ps

module dpbr_fabric
(
    output dpbr_pkg::dpbr_req_t req_o
);
    // ----------------------------------------
    // request issue
    // ----------------------------------------
    // port starts disabled
    initial req_o = '0;

    // enabled request, held until the next call
    task automatic put(logic we, logic rb, int w, logic [13:0] a,
                       logic [31:0] d, logic [3:0] p);
        dpbr_pkg::dpbr_req_t r; // whole request, driven in one step
        r.en = 1'h1;
        r.we = we;
        r.wr_mode = dpbr_pkg::dpbr_wmode_t'(rb);
        r.width = dpbr_pkg::dpbr_width_t'(w);
        r.addr = a;
        r.input_word = d;
        r.input_parity = p;
        req_o = r;
    endtask

    // disabled port: strobe up and data inverted, so a leak would show
    task automatic idle();
        dpbr_pkg::dpbr_req_t r; // whole request, driven in one step
        r = req_o;
        r.en = 1'h0;
        r.we = 1'h1;
        r.input_word = ~r.input_word;
        r.input_parity = ~r.input_parity;
        req_o = r;
    endtask
endmodule

/* File: testbench/testbench.sv */
// self-checking bench of the dual-port block ram
// assumes one 10 MHz clock; inputs change on the falling edge
`timescale 1ns/1ps

module testbench;
    // ----------------------------------------
    // clock, reset, wiring
    // ----------------------------------------
    logic mclk_i = 1'h0; // 100 ns period
    logic reset_i = 1'h1; // synchronous, active high
    dpbr_pkg::dpbr_req_t req_a; // port a request
    dpbr_pkg::dpbr_req_t req_b; // port b request
    dpbr_pkg::dpbr_resp_t resp_a; // port a answer
    dpbr_pkg::dpbr_resp_t resp_b; // port b answer
    int n_fail = 0; // mismatches
    int samples_checked = 0; // comparisons
    // lane masks per width code
    logic [31:0] dm [6] = '{32'h1, 32'h3, 32'hf, 32'hff, 32'hffff,
                            32'hffffffff};
    logic [3:0] pm [6] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h3, 4'hf};

    always #50 mclk_i = ~mclk_i;

    dpbr_fabric fab_a (.req_o(req_a));
    dpbr_fabric fab_b (.req_o(req_b));
    dpbr_top dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .port_a_i(req_a),
                    .port_b_i(req_b), .resp_a_o(resp_a), .resp_b_o(resp_b));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // compare one port answer
    task automatic chk(dpbr_pkg::dpbr_resp_t got, dpbr_pkg::dpbr_resp_t e);
        samples_checked++;
        if (got !== e)
        begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, e);
        end
    endtask

    // expected answer: word and parity cut to the lane width
    function automatic dpbr_pkg::dpbr_resp_t fit(int w, logic [31:0] d,
                                                 logic [3:0] p);
        dpbr_pkg::dpbr_resp_t r; // expected answer
        r.output_word = d & dm[w];
        r.output_parity = p & pm[w];
        return r;
    endfunction

    // one edge, then settle at the falling edge
    task automatic cyc();
        @(posedge mclk_i);
        @(negedge mclk_i);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // every width: top address, alias neighbour, read back
    task automatic s_widths();
        logic [13:0] b;
        for (int w = 0; w < 6; w++)
        begin
            b = 14'h3fff ^ 14'(14'h1 << (13 - w));
            fab_a.put(1'h1, 1'h0, w, 14'h3fff, 32'ha5c396e1, 4'h9);
            cyc();
            chk(resp_a, fit(w, 32'ha5c396e1, 4'h9));
            fab_a.put(1'h1, 1'h0, w, b, 32'h5a3c691e, 4'h6);
            cyc();
            chk(resp_a, fit(w, 32'h5a3c691e, 4'h6));
            fab_a.put(1'h0, 1'h0, w, 14'h3fff, 32'h0, 4'h0);
            cyc();
            chk(resp_a, fit(w, 32'ha5c396e1, 4'h9));
        end
    endtask

    // write modes back to back, then a disabled port holds
    task automatic s_modes();
        fab_a.put(1'h1, 1'h0, 5, 14'h0010, 32'h11223344, 4'h3);
        cyc();
        chk(resp_a, fit(5, 32'h11223344, 4'h3));
        fab_a.put(1'h1, 1'h1, 5, 14'h0010, 32'hcafe0001, 4'hc);
        cyc();
        chk(resp_a, fit(5, 32'h11223344, 4'h3));
        fab_a.put(1'h0, 1'h0, 5, 14'h0010, 32'hcafe0001, 4'hc);
        cyc();
        chk(resp_a, fit(5, 32'hcafe0001, 4'hc));
        fab_a.idle();
        cyc();
        chk(resp_a, fit(5, 32'hcafe0001, 4'hc));
        cyc();
        chk(resp_a, fit(5, 32'hcafe0001, 4'hc));
        fab_a.put(1'h0, 1'h0, 5, 14'h0010, 32'h0, 4'h0);
        cyc();
        chk(resp_a, fit(5, 32'hcafe0001, 4'hc));
    endtask

    // both ports write on one edge, then read each other's word
    task automatic s_dual();
        fab_b.put(1'h1, 1'h0, 3, 14'h0100, 32'h0000005a, 4'h0);
        cyc();
        chk(resp_b, fit(3, 32'h0000005a, 4'h0));
        fab_a.put(1'h1, 1'h0, 4, 14'h0040, 32'h0000beef, 4'h2);
        fab_b.put(1'h1, 1'h1, 3, 14'h0100, 32'h0000007e, 4'h1);
        cyc();
        chk(resp_a, fit(4, 32'h0000beef, 4'h2));
        chk(resp_b, fit(3, 32'h0000005a, 4'h0));
        fab_a.put(1'h0, 1'h0, 3, 14'h0100, 32'h0, 4'h0);
        fab_b.put(1'h0, 1'h0, 4, 14'h0040, 32'h0, 4'h0);
        cyc();
        chk(resp_a, fit(3, 32'h0000007e, 4'h1));
        chk(resp_b, fit(4, 32'h0000beef, 4'h2));
        fab_a.idle();
        fab_b.idle();
        cyc();
        chk(resp_b, fit(4, 32'h0000beef, 4'h2));
    endtask

    // mid-run reset clears both outputs but keeps the array
    task automatic s_reset();
        fab_a.put(1'h0, 1'h0, 5, 14'h0010, 32'h0, 4'h0);
        reset_i = 1'h1;
        cyc();
        chk(resp_a, '0);
        chk(resp_b, '0);
        reset_i = 1'h0;
        cyc();
        chk(resp_a, fit(5, 32'hcafe0001, 4'hc));
        chk(resp_b, '0);
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (12) @(negedge mclk_i);
        reset_i = 1'h0;
        chk(resp_a, '0);
        chk(resp_b, '0);
        s_widths();
        s_modes();
        s_dual();
        s_reset();
        conclude();
    end

    // a hang ends the run as a failure
    initial
    begin
        repeat (2000) @(posedge mclk_i);
        n_fail++;
        conclude();
    end
endmodule
